/* File: rtl/ebpsc_top.sv */
// External bus pin state control: pin levels per operating state.
// Assumes the core gives access requests; pins resolved outside.
// What this block does
// - Internal memory access: strobes inactive, data floated
// - Peripheral access: address out, data floated
// - Reset floats all; then port input
// - Idle/stop: float address, clock low, strobes high
// - Wait ignored in idle and gaps; hold too
// - Gap state holds address, strobes high
// - Gap after T3 muxed, T2 separate
// - Hold: float bus, acknowledge low, clock runs
// - Sixteen muxed lines, separate address, four selects
`timescale 1ns/1ps
`include "ebpsc_defs.svh"
module ebpsc_top (
    // Clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_b,
    // Core side
    input  wire logic                      i_bus_enable,
    input  wire logic                      i_separate_mode,
    input  wire ebpsc_pkg::ebpsc_pwr_t     i_power_state,
    input  wire logic                      i_ext_req,
    input  wire logic                      i_ext_write,
    input  wire logic [1:0]                i_ext_byte_en,
    input  wire logic [23:0]               i_ext_addr,
    input  wire logic [`EBPSC_AD_W-1:0]    i_ext_wdata,
    input  wire logic [`EBPSC_CS_W-1:0]    i_ext_cs,
    input  wire logic                      i_periph_req,
    input  wire logic [23:0]               i_periph_addr,
    output logic                           o_ext_done,
    output logic [`EBPSC_AD_W-1:0]         o_ext_rdata,
    output logic                           o_bus_granted,
    // Multiplexed address/data lines
    input  wire logic [`EBPSC_AD_W-1:0]    i_addr_data_lines,
    output logic [`EBPSC_AD_W-1:0]         o_addr_data_lines,
    output logic                           o_addr_data_lines_oe,
    // Separate address lines
    output logic [`EBPSC_LA_W-1:0]         o_lower_address_lines,
    output logic [`EBPSC_UA_W-1:0]         o_upper_address_lines,
    output logic                           o_address_oe,
    // Control strobes
    output logic [`EBPSC_CS_W-1:0]         o_chip_select_n,
    output logic [1:0]                     o_write_strobe_n,
    output logic                           o_read_strobe_n,
    output logic                           o_address_latch_strobe,
    output logic                           o_hold_acknowledge_n,
    output logic                           o_bus_clock_output,
    output logic                           o_ctrl_oe,
    output logic                           o_clock_oe,
    output logic                           o_hold_acknowledge_oe,
    // Inputs sampled through synchronisers
    input  wire logic                      i_wait_n,
    input  wire logic                      i_hold_request_n
);
    import ebpsc_pkg::*;

    ebpsc_sync_if sif ();
    assign sif.raw_wait_n         = i_wait_n;
    assign sif.raw_hold_request_n = i_hold_request_n;
    ebpsc_sync u_sync (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .s       (sif)
    );

    ////////////////////////////////////////////////////////////////////
    ebpsc_st_t  st_q;
    logic [1:0] t_q;
    logic       low_power;
    logic       wr_q;
    logic [1:0] tlast;
    assign low_power = (i_power_state == EBPSC_PWR_IDLE);
    assign tlast = i_separate_mode ? `EBPSC_TLAST_SEP : `EBPSC_TLAST_MUX;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= EBPSC_ST_PORT;
            t_q  <= `EBPSC_T1;
            wr_q <= 1'b0;
        end else begin
            unique case (st_q)
                EBPSC_ST_PORT: begin
                    if (i_bus_enable) st_q <= EBPSC_ST_REST;
                end
                EBPSC_ST_REST: begin
                    if (!i_bus_enable) st_q <= EBPSC_ST_PORT;
                    else if (!low_power && !sif.hold_request_n)
                        st_q <= EBPSC_ST_HOLD;
                    else if (!low_power && i_ext_req) begin
                        st_q <= EBPSC_ST_CYC;
                        t_q  <= `EBPSC_T1;
                        wr_q <= i_ext_write;
                    end
                end
                EBPSC_ST_CYC: begin
                    // Wait sampled only in cycle states
                    // Last state tested first: separate mode never waits
                    if (t_q == tlast) st_q <= EBPSC_ST_GAP;
                    else if (t_q != `EBPSC_T1 && !sif.wait_n) t_q <= t_q;
                    else t_q <= t_q + 2'h1;
                end
                EBPSC_ST_GAP: st_q <= EBPSC_ST_REST;
                EBPSC_ST_HOLD: begin
                    if (sif.hold_request_n) st_q <= EBPSC_ST_REST;
                end
                default: st_q <= EBPSC_ST_PORT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic cyc;
    logic last_t;
    assign cyc    = (st_q == EBPSC_ST_CYC);
    assign last_t = cyc && (t_q == tlast);

    // Pin drivers, registered
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_addr_data_lines      <= '0;
            o_addr_data_lines_oe   <= 1'b0;
            o_lower_address_lines  <= '0;
            o_upper_address_lines  <= '0;
            o_address_oe           <= 1'b0;
            o_chip_select_n        <= '1;
            o_write_strobe_n       <= 2'h3;
            o_read_strobe_n        <= 1'b1;
            o_address_latch_strobe <= 1'b1;
            o_hold_acknowledge_n   <= 1'b1;
            o_bus_clock_output     <= 1'b0;
            o_ctrl_oe              <= 1'b0;
            o_clock_oe             <= 1'b0;
            o_hold_acknowledge_oe  <= 1'b0;
            o_ext_done             <= 1'b0;
            o_ext_rdata            <= '0;
            o_bus_granted          <= 1'b0;
        end else begin
            o_ext_done    <= 1'b0;
            o_bus_granted <= (st_q == EBPSC_ST_HOLD);
            // Port mode until the bus is enabled
            o_ctrl_oe  <= (st_q != EBPSC_ST_PORT) && (st_q != EBPSC_ST_HOLD);
            o_clock_oe <= (st_q != EBPSC_ST_PORT);
            // Halt runs like normal; clock low in idle/stop
            o_bus_clock_output <= low_power ? 1'b0 : ~o_bus_clock_output;
            o_hold_acknowledge_n <= (st_q != EBPSC_ST_HOLD);
            // Own enable: acknowledge and bus clock are driven while the rest float
            o_hold_acknowledge_oe <= (st_q != EBPSC_ST_PORT);
            unique case (st_q)
                EBPSC_ST_CYC: begin
                    // Split address beside the muxed lines
                    o_address_oe <= 1'b1;
                    o_lower_address_lines <= i_ext_addr[15:0];
                    o_upper_address_lines <= i_ext_addr[23:16];
                    o_chip_select_n <= ~i_ext_cs;
                    o_address_latch_strobe <= (t_q != `EBPSC_T1);
                    // Muxed lines carry address in T1 in muxed mode, then data
                    o_addr_data_lines <= (t_q == `EBPSC_T1 && !i_separate_mode)
                                         ? i_ext_addr[15:0] : i_ext_wdata;
                    o_addr_data_lines_oe <= (t_q == `EBPSC_T1 &&
                        !i_separate_mode) || wr_q;
                    o_read_strobe_n  <= wr_q || (t_q == `EBPSC_T1);
                    o_write_strobe_n <= (wr_q && t_q != `EBPSC_T1)
                                        ? ~i_ext_byte_en : 2'h3;
                end
                // Gap holds address and selects, strobes high
                EBPSC_ST_GAP: begin
                    // Taken while the last state's strobe still stands
                    o_ext_done             <= 1'b1;
                    o_ext_rdata            <= i_addr_data_lines;
                    o_write_strobe_n       <= 2'h3;
                    o_read_strobe_n        <= 1'b1;
                    o_address_latch_strobe <= 1'b1;
                end
                default: begin
                    o_addr_data_lines_oe   <= 1'b0;
                    o_write_strobe_n       <= 2'h3;
                    o_read_strobe_n        <= 1'b1;
                    o_address_latch_strobe <= 1'b1;
                    o_chip_select_n        <= '1;
                    o_address_oe <= i_periph_req && !low_power &&
                                    (st_q == EBPSC_ST_REST);
                    if (i_periph_req) begin
                        o_lower_address_lines <= i_periph_addr[15:0];
                        o_upper_address_lines <= i_periph_addr[23:16];
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Granted bus floats data and control
    property p_hold_float;
        @(posedge i_clock) disable iff (!i_rst_b)
        (st_q == EBPSC_ST_HOLD) |=> !o_ctrl_oe && !o_addr_data_lines_oe
            && !o_hold_acknowledge_n && o_hold_acknowledge_oe;
    endproperty
    a_hold_float: assert property (p_hold_float)
        else $error("hold state did not float bus");
    property p_idle_clk;
        @(posedge i_clock) disable iff (!i_rst_b)
        low_power |=> !o_bus_clock_output;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("clock output not low in idle");
    property p_gap;
        @(posedge i_clock) disable iff (!i_rst_b)
        (st_q == EBPSC_ST_GAP) |=> o_read_strobe_n && o_write_strobe_n == 2'h3
            && $stable(o_chip_select_n);
    endproperty
    a_gap: assert property (p_gap)
        else $error("gap state pins wrong");
    property p_gap_place;
        @(posedge i_clock) disable iff (!i_rst_b)
        last_t |=> (st_q == EBPSC_ST_GAP);
    endproperty
    a_gap_place: assert property (p_gap_place)
        else $error("gap not inserted after last state");
    property p_rest_strobe;
        @(posedge i_clock) disable iff (!i_rst_b)
        (st_q == EBPSC_ST_REST) |=> o_read_strobe_n && o_chip_select_n == '1;
    endproperty
    a_rest_strobe: assert property (p_rest_strobe)
        else $error("strobe active outside a cycle");
    property p_idle_nohold;
        @(posedge i_clock) disable iff (!i_rst_b)
        (st_q == EBPSC_ST_REST && low_power) |=> st_q != EBPSC_ST_HOLD;
    endproperty
    a_idle_nohold: assert property (p_idle_nohold)
        else $error("hold granted in idle");
    property p_port;
        @(posedge i_clock) disable iff (!i_rst_b)
        (st_q == EBPSC_ST_PORT) |=> !o_ctrl_oe && !o_clock_oe;
    endproperty
    a_port: assert property (p_port)
        else $error("pins driven in port mode");
    c_gap:  cover property (@(posedge i_clock) st_q == EBPSC_ST_GAP);
    c_hold: cover property (@(posedge i_clock) st_q == EBPSC_ST_HOLD);
    c_sep:  cover property (@(posedge i_clock) last_t && i_separate_mode);
endmodule // ebpsc_top

/* File: shared/ebpsc_defs.svh */
// Constants for the external bus pin state controller.
// Assumes inclusion by package and modules by bare name.
`ifndef EBPSC_DEFS_SVH
`define EBPSC_DEFS_SVH
`define EBPSC_AD_W      16
`define EBPSC_LA_W      16
`define EBPSC_UA_W      8
`define EBPSC_CS_W      4
`define EBPSC_TLAST_MUX 2'h2
`define EBPSC_TLAST_SEP 2'h1
`define EBPSC_T1        2'h0
`endif

/* File: shared/ebpsc_pkg.sv */
// Types for the external bus pin state controller.
// Assumes ebpsc_defs.svh is on the include path.
`include "ebpsc_defs.svh"
package ebpsc_pkg;
    typedef enum logic [2:0] {
        EBPSC_PWR_RUN  = 3'h1,
        EBPSC_PWR_HALT = 3'h2,
        EBPSC_PWR_IDLE = 3'h4
    } ebpsc_pwr_t;
    typedef enum logic [4:0] {
        EBPSC_ST_PORT = 5'h01,
        EBPSC_ST_REST = 5'h02,
        EBPSC_ST_CYC  = 5'h04,
        EBPSC_ST_GAP  = 5'h08,
        EBPSC_ST_HOLD = 5'h10
    } ebpsc_st_t;
endpackage

/* File: shared/ebpsc_sync_if.sv */
// Carrier for raw and synchronised pin inputs.
// Assumes one clock domain.
`timescale 1ns/1ps
interface ebpsc_sync_if;
    logic raw_wait_n;
    logic raw_hold_request_n;
    logic wait_n;
    logic hold_request_n;
    modport sync (input raw_wait_n, raw_hold_request_n,
                  output wait_n, hold_request_n);
    modport core (output raw_wait_n, raw_hold_request_n,
                  input wait_n, hold_request_n);
endinterface

/* File: rtl/ebpsc_sync.sv */
// Two-flop synchronisers for the wait and hold request pins.
// Assumes i_clock at 20 MHz and async active-low reset.
`timescale 1ns/1ps
module ebpsc_sync (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    // Pins
    ebpsc_sync_if.sync s
);
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
        end else begin
            s1_q <= {s.raw_hold_request_n, s.raw_wait_n};
            s2_q <= s1_q;
        end
    end
    assign s.wait_n         = s2_q[0];
    assign s.hold_request_n = s2_q[1];
endmodule // ebpsc_sync

/* File: bench/ebpsc_far_model.sv */
// Far side: external memory, wait source and bus hold master.
// Assumes the pins of ebpsc_top; resolves the shared data wire here.
`timescale 1ns/1ps
module ebpsc_far_model (
    // Clock and pins
    input  wire logic        i_clock,
    input  wire logic        i_sep,
    input  wire logic [15:0] i_ad,
    input  wire logic        i_ad_oe,
    input  wire logic [15:0] i_lower,
    input  wire logic [1:0]  i_wr_n,
    input  wire logic        i_rd_n,
    input  wire logic        i_ale,
    // Bench commands
    input  wire logic        i_hold,
    input  wire logic [3:0]  i_wait_len,
    // Lines driven back
    output logic [15:0]      o_ad_wire,
    output logic             o_wait_n,
    output logic             o_hold_request_n
);
    logic [15:0] mem [logic [15:0]];
    logic [15:0] key_q = 16'h0;
    logic [15:0] junk_q = 16'h5a5a;
    logic [3:0]  wcnt_q = 4'h0;
    logic        spent_q = 1'b0;
    // Far master asks for the bus
    assign o_hold_request_n = ~i_hold;
    // Wait leads the strobe: the pin reaches the core two clocks late
    assign o_wait_n = (i_wait_len == 4'h0) || spent_q;
    // Released wire must not keep the last value
    always @* begin
        if (i_ad_oe)
            o_ad_wire = i_ad;
        else if (!i_rd_n && mem.exists(key_q))
            o_ad_wire = mem[key_q];
        else
            o_ad_wire = junk_q;
    end
    always @(posedge i_clock) begin
        junk_q <= ~junk_q;
        if (i_wait_len == 4'h0) begin
            wcnt_q  <= 4'h0;
            spent_q <= 1'b0;
        end else if (!(i_rd_n & (&i_wr_n)) && !spent_q) begin
            wcnt_q  <= wcnt_q + 4'h1;
            spent_q <= (wcnt_q + 4'h1 == i_wait_len);
        end
        if (!i_ale)
            key_q <= i_sep ? i_lower : o_ad_wire;
        if (!mem.exists(key_q))
            mem[key_q] = 16'h0;
        if (!i_wr_n[0] && i_ad_oe)
            mem[key_q][7:0] = i_ad[7:0];
        if (!i_wr_n[1] && i_ad_oe)
            mem[key_q][15:8] = i_ad[15:8];
    end
endmodule // ebpsc_far_model

/* File: bench/tb_ext_bus_pin_state_control.sv */
// Bench for the bus pin state controller, with a reference memory.
// Assumes ebpsc_top and ebpsc_far_model; self-checking.
`timescale 1ns/1ps
module tb_ext_bus_pin_state_control;
    import ebpsc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, sep = 1'b0, req = 1'b0, wr = 1'b0;
    logic preq = 1'b0, hold = 1'b0, done, gnt, ad_oe, a_oe, rd_n, ale;
    logic hack, bclk, ctrl_oe, clk_oe, wait_n, hreq_n, b0, hack_oe, en = 1'b1;
    logic [7:0] hi;
    ebpsc_pwr_t pwr = EBPSC_PWR_RUN;
    logic [1:0] be = 2'h3, wr_n;
    logic [23:0] addr = 24'h0, paddr = 24'h0;
    logic [15:0] wd = 16'h0, rdata, ad_o, ad_w, lo, k;
    logic [3:0] cs = 4'h1, wl = 4'h0, sel_n;
    logic [15:0] model [logic [15:0]];
    int seed, err_count = 0, compares = 0, cycles = 0;
    always #25 clk = ~clk;
    ebpsc_top u_ebpsc_top (.i_clock(clk), .i_rst_b(rst_b),
        .i_bus_enable(en), .i_separate_mode(sep), .i_power_state(pwr),
        .i_ext_req(req), .i_ext_write(wr), .i_ext_byte_en(be),
        .i_ext_addr(addr), .i_ext_wdata(wd), .i_ext_cs(cs),
        .i_periph_req(preq), .i_periph_addr(paddr), .o_ext_done(done),
        .o_ext_rdata(rdata), .o_bus_granted(gnt), .i_addr_data_lines(ad_w),
        .o_addr_data_lines(ad_o), .o_addr_data_lines_oe(ad_oe),
        .o_lower_address_lines(lo), .o_upper_address_lines(hi),
        .o_hold_acknowledge_oe(hack_oe),
        .o_address_oe(a_oe), .o_chip_select_n(sel_n), .o_write_strobe_n(wr_n),
        .o_read_strobe_n(rd_n), .o_address_latch_strobe(ale),
        .o_hold_acknowledge_n(hack), .o_bus_clock_output(bclk),
        .o_ctrl_oe(ctrl_oe), .o_clock_oe(clk_oe), .i_wait_n(wait_n),
        .i_hold_request_n(hreq_n));
    ebpsc_far_model u_ebpsc_far_model (.i_clock(clk), .i_sep(sep),
        .i_ad(ad_o), .i_ad_oe(ad_oe), .i_lower(lo), .i_wr_n(wr_n),
        .i_rd_n(rd_n), .i_ale(ale), .i_hold(hold), .i_wait_len(wl),
        .o_ad_wire(ad_w), .o_wait_n(wait_n), .o_hold_request_n(hreq_n));
    task automatic step();
        @(posedge clk);
        #5;
    endtask
    task automatic chk_data(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pin(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(logic w, logic [1:0] b, logic [3:0] wlen);
        int n;
        int t1;
        int td;
        logic [2:0] stb;
        addr = {8'h00, k};
        wd = 16'($random(seed));
        cs = 4'h1 << ($unsigned($random(seed)) % 4);
        wr = w;
        be = b;
        wl = wlen;
        req = 1'b1;
        t1 = -1;
        td = -1;
        stb = 3'h7;
        for (n = 0; n < 40 && td < 0; n++) begin
            step();
            if (ale === 1'b0 && t1 < 0) t1 = n;
            if ({wr_n, rd_n} !== 3'h7) stb = {wr_n, rd_n};
            if (done === 1'b1) td = n;
        end
        req = 1'b0;
        chk_pin("gap", {~cs, 4'hf}, {sel_n, wr_n, rd_n, ale});
        step();
        chk_pin("lanes", w ? {~b, 1'b1} : 3'h6, stb);
        if (wlen == 4'h0 || sep)
            chk_pin("tstates", sep ? 2 : 3, td - t1);
        else
            chk_pin("waited", 1, (td - t1) > 3);
        if (!model.exists(k)) model[k] = 16'h0;
        if (w && b[0]) model[k][7:0] = wd[7:0];
        if (w && b[1]) model[k][15:8] = wd[15:8];
        if (!w) chk_data("rdata", model[k], rdata);
    endtask
    task automatic refuse();
        logic bad;
        bad = 1'b0;
        req = 1'b1;
        repeat (8) begin
            step();
            if (done !== 1'b0) bad = 1'b1;
        end
        req = 1'b0;
        chk_pin("refused", 0, bad);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        seed = 32'h5de03961;
        repeat (10) @(posedge clk);
        #5;
        chk_pin("rst_oe", 0, {ad_oe, a_oe, ctrl_oe, clk_oe, hack_oe});
        rst_b = 1'b1;
        step();
        chk_pin("port_oe", 0, {ad_oe, a_oe, ctrl_oe, clk_oe, hack_oe});
        for (int m = 0; m < 4; m++) begin
            sep = m[0];
            pwr = m[1] ? EBPSC_PWR_HALT : EBPSC_PWR_RUN;
            repeat (4) step();
            k = 16'($random(seed));
            xfer(1'b1, 2'h3, 4'h0);
            xfer(1'b1, m[0] ? 2'h1 : 2'h2, 4'h0);
            xfer(1'b0, 2'h3, 4'h0);
            xfer(1'b0, 2'h3, 4'h4);
            $display("test transfers mode %0d done", m);
        end
        paddr = 24'($random(seed));
        preq = 1'b1;
        repeat (3) step();
        chk_pin("periph", {paddr, 5'h0f},
            {hi, lo, ad_oe, a_oe, rd_n, wr_n});
        preq = 1'b0;
        hold = 1'b1;
        for (int n = 0; n < 10 && gnt !== 1'b1; n++) step();
        step();
        b0 = bclk;
        step();
        chk_pin("hold", 7'h03,
            {ad_oe, a_oe, ctrl_oe, hack, ~gnt, bclk ^ b0, hack_oe});
        refuse();
        hold = 1'b0;
        repeat (6) step();
        $display("test hold done");
        pwr = EBPSC_PWR_IDLE;
        hold = 1'b1;
        repeat (4) step();
        chk_pin("idle", 12'h1ff,
            {ad_oe, a_oe, bclk, sel_n, wr_n, rd_n, ale, hack});
        refuse();
        chk_pin("idle_hold", 0, gnt);
        hold = 1'b0;
        pwr = EBPSC_PWR_RUN;
        rst_b = 1'b0;
        en = 1'b0;
        step();
        chk_pin("rerst_oe", 0, {ad_oe, a_oe, ctrl_oe, clk_oe, hack_oe});
        rst_b = 1'b1;
        repeat (3) step();
        chk_pin("still_port", 0, {ctrl_oe, clk_oe, hack_oe});
        en = 1'b1;
        repeat (4) step();
        xfer(1'b0, 2'h3, 4'h0);
        $display("test idle and reset done");
        print_verdict();
    end
endmodule // tb_ext_bus_pin_state_control
